// file: rtl/hmrp_consts.svh
`ifndef HMRP_CONSTS_SVH
`define HMRP_CONSTS_SVH

`define HMRP_AXI_AW 4
`define HMRP_CTRL_OFS 4'h0
`define HMRP_STAT_OFS 4'h4
`define HMRP_CTRL_RST 32'h0000_0003
`define HMRP_CTRL_PUMP_BIT 0
`define HMRP_CTRL_IRQ_BIT 1
`define HMRP_STAT_STROBE_BIT 0
`define HMRP_STAT_RESET_BIT 1
`define HMRP_STAT_ISO_BIT 2
`define HMRP_STAT_PUMP_BIT 3
`define HMRP_STAT_TEST_BIT 4
`define HMRP_STAT_OSC_BIT 5
`define HMRP_RESP_OKAY 2'h0
`define HMRP_RESP_SLVERR 2'h2

`define HMRP_CLK_NS 8
`define HMRP_RST_MIN_NS 40
`define HMRP_RST_MIN_CYC ((`HMRP_RST_MIN_NS + `HMRP_CLK_NS - 1) / `HMRP_CLK_NS)
`define HMRP_RST_SYNC_LEN 6

`define HMRP_PIN_W 13
`define HMRP_PIN_STYLE 0
`define HMRP_PIN_RESET 1
`define HMRP_PIN_ISO 2
`define HMRP_PIN_PUMP 3
`define HMRP_PIN_OSC 4
`define HMRP_PIN_T0 5
`define HMRP_PIN_T1 6
`define HMRP_PIN_T2 7
`define HMRP_PIN_RD 8
`define HMRP_PIN_WR 9
`define HMRP_PIN_CS 10
`define HMRP_PIN_RX 11
`define HMRP_PIN_LOWSUP 12

`endif

// file: rtl/hmrp_pkg.sv
package hmrp_pkg;
  typedef enum logic {hmrp_bus_dirline, hmrp_bus_strobe} hmrp_bus_t;
  typedef enum logic [1:0] {hmrp_st_run, hmrp_st_qual, hmrp_st_held} hmrp_rst_st_t;
endpackage

// file: rtl/hmrp_pin_sync.sv
`timescale 1ns/100ps
module hmrp_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import hmrp_pkg::*;
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_level;

  // Value moves only once stages two and three agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule

// file: rtl/hmrp_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "hmrp_consts.svh"
// How it works
// R1: Select pin high gives a strobe bus with separate read and write strobes.
// R2: Select pin low gives a direction-line bus using read/write plus chip select.
// R3: In strobe mode the reset pin is active high.
// R4: In direction-line mode the reset pin is active low.
// R5: Reset held 40 ns or longer returns registers and outputs to defaults; a pin reset here leaves pump_off and the AXI response registers running.
// R6: During reset transmit stays idle high and receive input is ignored.
// R7: Power-save input high blocks host bus activity from internal logic.
// R8: Pump autosleep on low supply stops pump only when oscillator output is low.
// R9: System keeps all factory test inputs low in normal operation.
// R10: In direction-line mode the read strobe input is ignored.
// R11: In direction-line mode write strobe high means read, low means write.
// R12: In direction-line mode interrupt output is active low open drain.
// R13: Internal reset asserts asynchronously and releases synchronously to clock.
module hmrp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_style_sel,
  input wire logic reset_pin,
  input wire logic bus_isolate_request,
  input wire logic pump_autosleep,
  input wire logic oscillator_output,
  input wire logic low_supply_sel,
  input wire logic factory_test_in0,
  input wire logic factory_test_in1,
  input wire logic factory_test_in2,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_n,
  input wire logic serial_rx_pin,
  input wire logic core_tx,
  input wire logic core_irq,
  output logic core_reset,
  output logic host_read_pulse,
  output logic host_write_pulse,
  output logic serial_tx_pin,
  output logic core_rx,
  output logic int_out,
  output logic int_oe,
  output logic pump_off,
  input wire logic [`HMRP_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`HMRP_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import hmrp_pkg::*;

  localparam logic [2:0] MIN_CYC = 3'(`HMRP_RST_MIN_CYC);

  // Internal reset: async assert, release after a clocked shift
  logic [`HMRP_RST_SYNC_LEN-1:0] rsync;
  logic rst_int;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsync <= '1; // R13
    end else begin
      rsync <= {rsync[`HMRP_RST_SYNC_LEN-2:0], 1'b0}; // R13
    end
  end
  assign rst_int = rsync[`HMRP_RST_SYNC_LEN-1];

  logic [`HMRP_PIN_W-1:0] pins_raw, pins;
  assign pins_raw = {low_supply_sel, serial_rx_pin, chip_select_n, write_strobe_n,
                     read_strobe_n, factory_test_in2, factory_test_in1, factory_test_in0,
                     oscillator_output, pump_autosleep, bus_isolate_request, reset_pin,
                     bus_style_sel};
  hmrp_pin_sync #(.W(`HMRP_PIN_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin(pins_raw),
    .level(pins)
  );
  logic iso_s, rd_s, wr_s, cs_s, osc_s, test_active;
  assign iso_s = pins[`HMRP_PIN_ISO];
  assign rd_s = pins[`HMRP_PIN_RD];
  assign wr_s = pins[`HMRP_PIN_WR];
  assign cs_s = pins[`HMRP_PIN_CS];
  assign osc_s = pins[`HMRP_PIN_OSC];
  assign test_active = |pins[`HMRP_PIN_T2:`HMRP_PIN_T0]; // R9

  // Strap and reset qualification
  hmrp_bus_t bus_style, next_bus_style;
  hmrp_rst_st_t rst_st, next_rst_st;
  logic [2:0] rst_cnt, next_rst_cnt;
  logic pin_active, bus_strobe;
  assign bus_strobe = (bus_style == hmrp_bus_strobe);
  assign pin_active = bus_strobe ? pins[`HMRP_PIN_RESET] : ~pins[`HMRP_PIN_RESET]; // R3 R4
  assign core_reset = rst_int | (rst_st == hmrp_st_held); // R5

  always_comb begin
    next_rst_st = rst_st;
    next_rst_cnt = rst_cnt;
    // Strap follows the pin only while in reset, so mode never flips mid-transfer
    next_bus_style = core_reset ? (pins[`HMRP_PIN_STYLE] ? hmrp_bus_strobe : hmrp_bus_dirline)
                                : bus_style; // R1 R2
    case (rst_st)
      hmrp_st_run: begin
        if (pin_active) begin
          next_rst_st = hmrp_st_qual;
          next_rst_cnt = 3'h1;
        end
      end
      hmrp_st_qual: begin
        if (!pin_active) begin
          next_rst_st = hmrp_st_run;
        end else if (rst_cnt == MIN_CYC - 3'h1) begin
          next_rst_st = hmrp_st_held; // R5
        end else begin
          next_rst_cnt = rst_cnt + 3'h1;
        end
      end
      hmrp_st_held: begin
        if (!pin_active) begin
          next_rst_st = hmrp_st_run;
        end
      end
      default: next_rst_st = hmrp_st_run;
    endcase
  end

  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      rst_st <= hmrp_st_run;
      rst_cnt <= 3'h0;
    end else begin
      rst_st <= next_rst_st;
      rst_cnt <= next_rst_cnt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_style <= hmrp_bus_strobe;
    end else begin
      bus_style <= next_bus_style;
    end
  end

  // Software control
  logic [31:0] ctrl, next_ctrl;

  // Host bus decode; edge history runs during isolation so wake-up sees no stale edge
  logic prev_rd, prev_wr, prev_cs;
  logic next_rd_pulse, next_wr_pulse;
  logic next_tx, next_rx, next_int, next_int_oe, next_pump;
  always_comb begin
    next_rd_pulse = 1'b0;
    next_wr_pulse = 1'b0;
    if (bus_strobe) begin
      next_rd_pulse = prev_rd & ~rd_s & ~cs_s; // R1
      next_wr_pulse = ~prev_wr & wr_s & ~cs_s; // R1
    end else if (prev_cs & ~cs_s) begin
      next_rd_pulse = wr_s; // R2 R10 R11
      next_wr_pulse = ~wr_s; // R11
    end
    if (iso_s || core_reset) begin
      next_rd_pulse = 1'b0; // R7
      next_wr_pulse = 1'b0; // R7
    end
    next_tx = core_reset ? 1'b1 : core_tx; // R6
    next_rx = core_reset ? 1'b1 : pins[`HMRP_PIN_RX]; // R6
    if (core_reset) begin
      next_int = 1'b0;
      next_int_oe = 1'b0;
    end else if (bus_strobe) begin
      next_int = core_irq & ctrl[`HMRP_CTRL_IRQ_BIT];
      next_int_oe = ctrl[`HMRP_CTRL_IRQ_BIT];
    end else begin
      next_int = 1'b0; // R12
      next_int_oe = core_irq; // R12
    end
    next_pump = pins[`HMRP_PIN_PUMP] & pins[`HMRP_PIN_LOWSUP] & ~osc_s
                & ctrl[`HMRP_CTRL_PUMP_BIT]; // R8
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_rd <= 1'b1;
      prev_wr <= 1'b1;
      prev_cs <= 1'b1;
      host_read_pulse <= 1'b0;
      host_write_pulse <= 1'b0;
      serial_tx_pin <= 1'b1;
      core_rx <= 1'b1;
      int_out <= 1'b0;
      int_oe <= 1'b0;
      pump_off <= 1'b0;
    end else begin
      prev_rd <= rd_s;
      prev_wr <= wr_s;
      prev_cs <= cs_s;
      host_read_pulse <= next_rd_pulse;
      host_write_pulse <= next_wr_pulse;
      serial_tx_pin <= next_tx;
      core_rx <= next_rx;
      int_out <= next_int;
      int_oe <= next_int_oe;
      pump_off <= next_pump;
    end
  end

  // AXI4-Lite slave: address and data taken together, one answer outstanding
  logic wr_go, rd_go;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, status;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  always_comb begin
    status = 32'h0;
    status[`HMRP_STAT_STROBE_BIT] = bus_strobe;
    status[`HMRP_STAT_RESET_BIT] = core_reset;
    status[`HMRP_STAT_ISO_BIT] = iso_s;
    status[`HMRP_STAT_PUMP_BIT] = pump_off;
    status[`HMRP_STAT_TEST_BIT] = test_active; // R9
    status[`HMRP_STAT_OSC_BIT] = osc_s;
    next_ctrl = ctrl;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = `HMRP_RESP_SLVERR;
      if (s_axi_awaddr == `HMRP_CTRL_OFS) begin
        next_bresp = `HMRP_RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb[b]) begin
            next_ctrl[8*b +: 8] = s_axi_wdata[8*b +: 8];
          end
        end
        next_ctrl[31:2] = 30'h0;
      end else if (s_axi_awaddr == `HMRP_STAT_OFS) begin
        next_bresp = `HMRP_RESP_OKAY;
      end
    end
    // Qualified pin reset returns software control to defaults as well
    if (rst_st == hmrp_st_held) begin
      next_ctrl = `HMRP_CTRL_RST; // R5
    end
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = `HMRP_RESP_OKAY;
      case (s_axi_araddr)
        `HMRP_CTRL_OFS: next_rdata = ctrl;
        `HMRP_STAT_OFS: next_rdata = status;
        default: begin
          next_rdata = 32'h0;
          next_rresp = `HMRP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      ctrl <= `HMRP_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_int);

  a_reset_qualifies: assert property ((rst_st == hmrp_st_run && pin_active) // R5
    ##1 pin_active [*4] |=> core_reset) else $error("reset held five cycles not taken");
  a_short_pulse_dropped: assert property ((rst_st == hmrp_st_run && pin_active) // R5
    ##1 !pin_active |=> !core_reset) else $error("short reset pulse acted");
  a_pol_strobe: assert property (bus_strobe && !pins[`HMRP_PIN_RESET] // R3
    && rst_st == hmrp_st_run |=> rst_st == hmrp_st_run)
    else $error("strobe mode low reset pin acted");
  a_pol_dirline: assert property (!bus_strobe && pins[`HMRP_PIN_RESET] // R4
    && rst_st == hmrp_st_run |=> rst_st == hmrp_st_run)
    else $error("direction mode high reset pin acted");
  a_tx_idle_reset: assert property (core_reset |=> serial_tx_pin && core_rx) // R6
    else $error("serial pins active during reset");
  a_isolate_quiet: assert property (iso_s |=> !host_read_pulse && !host_write_pulse) // R7
    else $error("host access while isolated");
  a_pump_awake: assert property (osc_s |=> !pump_off) // R8
    else $error("pump off with oscillator running");
  a_rd_ignored: assert property (!bus_strobe && $past(cs_s) && cs_s |=> !host_read_pulse) // R10
    else $error("read strobe acted in direction mode");
  a_dir_read: assert property (!bus_strobe && prev_cs && !cs_s && wr_s && !iso_s // R11
    && !core_reset |=> host_read_pulse && !host_write_pulse)
    else $error("direction read missed");
  a_strobe_write: assert property (bus_strobe && !prev_wr && wr_s && !cs_s && !iso_s // R1
    && !core_reset |=> host_write_pulse) else $error("strobe write missed");
  a_irq_opendrain: assert property (!bus_strobe && $past(!bus_strobe) |-> !int_out) // R12
    else $error("direction mode interrupt drove high");

  c_reset_held: cover property (rst_st == hmrp_st_held);
  c_host_read: cover property (host_read_pulse);
  c_host_write: cover property (host_write_pulse);
  c_pump_off: cover property (pump_off);
endmodule

// file: dv/hmrp_host_model.sv
`timescale 1ns/100ps
module hmrp_host_model (
  input wire logic clk,
  input wire logic dir_mode,
  input wire logic start,
  input wire logic is_write,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic busy
);
  logic rd_q;
  logic toggle = 1'b0;
  always @(posedge clk) toggle <= ~toggle;
  // Unused in direction mode, so it wanders every cycle
  assign read_strobe_n = dir_mode ? toggle : rd_q;
  // Each level held well over the 2-clock minimum
  task automatic hold();
    repeat (6) @(posedge clk);
  endtask
  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    rd_q = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start && !busy) begin
        busy <= 1'b1;
        if (dir_mode) begin
          write_strobe_n <= !is_write;
          hold();
          chip_select_n <= 1'b0;
          hold();
          chip_select_n <= 1'b1;
          hold();
          write_strobe_n <= 1'b1;
        end else begin
          chip_select_n <= 1'b0;
          hold();
          if (is_write) begin
            write_strobe_n <= 1'b0;
          end else begin
            rd_q <= 1'b0;
          end
          hold();
          write_strobe_n <= 1'b1;
          rd_q <= 1'b1;
          hold();
          chip_select_n <= 1'b1;
        end
        hold();
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/100ps
`include "hmrp_consts.svh"
module tb_top;
  logic clk, rst, bus_style_sel, reset_pin, bus_isolate_request, pump_autosleep;
  logic oscillator_output, low_supply_sel, factory_test_in0, factory_test_in1;
  logic factory_test_in2, read_strobe_n, write_strobe_n, chip_select_n;
  logic serial_rx_pin, core_tx, core_irq, core_reset, host_read_pulse, host_write_pulse;
  logic serial_tx_pin, core_rx, int_out, int_oe, pump_off;
  logic [`HMRP_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic start, is_write, busy;
  int err_total, compares, n_rd, n_wr;

  hmrp_top u_hmrp_top (
    .clk(clk), .rst(rst), .bus_style_sel(bus_style_sel), .reset_pin(reset_pin),
    .bus_isolate_request(bus_isolate_request), .pump_autosleep(pump_autosleep),
    .oscillator_output(oscillator_output), .low_supply_sel(low_supply_sel),
    .factory_test_in0(factory_test_in0), .factory_test_in1(factory_test_in1),
    .factory_test_in2(factory_test_in2), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
    .serial_rx_pin(serial_rx_pin), .core_tx(core_tx), .core_irq(core_irq),
    .core_reset(core_reset), .host_read_pulse(host_read_pulse),
    .host_write_pulse(host_write_pulse), .serial_tx_pin(serial_tx_pin), .core_rx(core_rx),
    .int_out(int_out), .int_oe(int_oe), .pump_off(pump_off),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  hmrp_host_model u_hmrp_host_model (.clk(clk), .dir_mode(!bus_style_sel), .start(start),
    .is_write(is_write), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (host_read_pulse === 1'b1) n_rd++;
    if (host_write_pulse === 1'b1) n_wr++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic ad, wd;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 0;
    wd = 0;
    n = 0;
    while (!(ad && wd) && n < 50) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("bvalid", 1, s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    chk("rvalid", 1, s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic do_rst(input logic strobe);
    @(posedge clk);
    rst <= 1'b1;
    bus_style_sel <= strobe;
    reset_pin <= !strobe;
    cyc(3);
    chk("core_reset in rst", 1, core_reset);
    chk("tx in rst", 1, serial_tx_pin);
    @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk("core_reset held", 1, core_reset);
    cyc(16);
    chk("core_reset out", 0, core_reset);
    axi_rd(`HMRP_STAT_OFS);
    chk("status style", strobe, d[`HMRP_STAT_STROBE_BIT]);
    chk("status test", 0, d[`HMRP_STAT_TEST_BIT]);
  endtask
  task automatic host_op(input logic w, input int er, input int ew);
    int r0, w0, n;
    r0 = n_rd;
    w0 = n_wr;
    @(posedge clk);
    start <= 1'b1;
    is_write <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b1 && n < 10);
    start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 100);
    cyc(8);
    chk("read pulses", er, n_rd - r0);
    chk("write pulses", ew, n_wr - w0);
  endtask
  task automatic pin_rst(input logic act);
    axi_wr(`HMRP_CTRL_OFS, 32'h0000_0000, `HMRP_RESP_OKAY);
    @(posedge clk);
    reset_pin <= act;
    serial_rx_pin <= 1'b0;
    cyc(2);
    reset_pin <= !act;
    cyc(12);
    chk("short pulse", 0, core_reset);
    reset_pin <= act;
    cyc(12);
    chk("pin reset", 1, core_reset);
    chk("tx idle", 1, serial_tx_pin);
    chk("rx ignored", 1, core_rx);
    reset_pin <= !act;
    cyc(12);
    chk("pin release", 0, core_reset);
    chk("tx follows", 0, serial_tx_pin);
    chk("rx follows", 0, core_rx);
    serial_rx_pin <= 1'b1;
    axi_rd(`HMRP_CTRL_OFS);
    chk("ctrl after pin reset", `HMRP_CTRL_RST, d);
  endtask
  task automatic regs_test();
    axi_rd(`HMRP_CTRL_OFS);
    chk("ctrl reset", `HMRP_CTRL_RST, d);
    axi_rd(4'h8);
    chk("rresp unmapped", `HMRP_RESP_SLVERR, r);
    axi_wr(4'hc, 32'h0000_0001, `HMRP_RESP_SLVERR);
    axi_wr(`HMRP_STAT_OFS, 32'hffff_ffff, `HMRP_RESP_OKAY);
  endtask
  task automatic iso_test();
    @(posedge clk);
    bus_isolate_request <= 1'b1;
    cyc(8);
    host_op(1'b0, 0, 0);
    host_op(1'b1, 0, 0);
    axi_rd(`HMRP_STAT_OFS);
    chk("status iso", 1, d[`HMRP_STAT_ISO_BIT]);
    bus_isolate_request <= 1'b0;
    cyc(8);
  endtask
  task automatic pump_test();
    @(posedge clk);
    low_supply_sel <= 1'b1;
    pump_autosleep <= 1'b1;
    cyc(8);
    chk("pump osc running", 0, pump_off);
    oscillator_output <= 1'b0;
    cyc(8);
    chk("pump asleep", 1, pump_off);
    axi_wr(`HMRP_CTRL_OFS, 32'h0000_0002, `HMRP_RESP_OKAY);
    cyc(4);
    chk("pump disabled", 0, pump_off);
    axi_wr(`HMRP_CTRL_OFS, 32'h0000_0003, `HMRP_RESP_OKAY);
    cyc(4);
    chk("pump enabled", 1, pump_off);
    low_supply_sel <= 1'b0;
    cyc(8);
    chk("pump high supply", 0, pump_off);
    oscillator_output <= 1'b1;
    pump_autosleep <= 1'b0;
  endtask
  task automatic irq_strobe_test();
    @(posedge clk);
    core_irq <= 1'b1;
    cyc(3);
    chk("irq strobe level", 1, int_out);
    chk("irq strobe oe", 1, int_oe);
    axi_wr(`HMRP_CTRL_OFS, 32'h0000_0001, `HMRP_RESP_OKAY);
    cyc(3);
    chk("irq three-state oe", 0, int_oe);
    chk("irq three-state level", 0, int_out);
    core_irq <= 1'b0;
    axi_wr(`HMRP_CTRL_OFS, `HMRP_CTRL_RST, `HMRP_RESP_OKAY);
  endtask
  task automatic irq_dir_test();
    @(posedge clk);
    core_irq <= 1'b1;
    cyc(3);
    chk("irq oe", 1, int_oe);
    chk("irq level", 0, int_out);
    core_irq <= 1'b0;
    cyc(3);
    chk("irq released", 0, int_oe);
  endtask

  initial begin
    {rst, bus_style_sel, oscillator_output, serial_rx_pin} = 4'hf;
    {reset_pin, bus_isolate_request, pump_autosleep, low_supply_sel} = 4'h0;
    {factory_test_in0, factory_test_in1, factory_test_in2} = 3'h0;
    {core_tx, core_irq, start, is_write} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    do_rst(1'b1);
    regs_test();
    host_op(1'b0, 1, 0);
    host_op(1'b1, 0, 1);
    pin_rst(1'b1);
    iso_test();
    pump_test();
    irq_strobe_test();
    do_rst(1'b0);
    host_op(1'b0, 1, 0);
    host_op(1'b1, 0, 1);
    pin_rst(1'b0);
    irq_dir_test();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
